// ==== rtl/eeprom_dev.sv ====
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - 8192 byte locations reachable over the bus
// R2 - Slave only; Start, select byte, acknowledge
// R3 - Acknowledge each received byte; master acknowledges reads
// R4 - Master stops after ack (write), no-ack (read)
// R5 - Held reset ignores all bus activity
// R6 - Data line driven open-drain only
// R7 - Straps compared with select bits b3..b1
// R8 - Guard high blocks writes to top quarter
// R9 - Unconnected guard reads as low; the guard input has no pull-down, a floating pin is sampled as is
// R10 - Select byte: type, strap, direction, MSB first
// R11 - Sixteen address bits in two bytes
// R12 - Start: data falls while clock high
// R13 - Watch Start always except during write
// R14 - Stop: data rises while clock high
// R15 - Unacknowledged read then Stop gives standby
// R16 - Stop closing write starts write cycle
// R17 - Transmitter releases; receiver pulls ninth bit
// R18 - Data captured on rising clock edge
// R19 - Master changes data only while clock low
// R20 - Master starts transfers and makes clock
// R21 - Works at serial clock up to 400 kHz
// R22 - Byte writes and page writes to 32
// R23 - Upper address byte sent first
// R24 - Strap mismatch deselects to standby
module eeprom_dev
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WR_CYCLES
) (
  // Clock and power-on reset
  input wire logic CLK,
  input wire logic RST_N,
  // Serial link
  two_wire_if.device link,
  // Straps and write guard
  input wire logic STRAP_ADDR_BIT0,
  input wire logic STRAP_ADDR_BIT1,
  input wire logic STRAP_ADDR_BIT2,
  input wire logic UPPER_QUARTER_WRITE_GUARD,
  // Status
  output logic BUSY
);

  typedef enum logic [2:0] {D_IDLE, D_SEL, D_ADDR_HI, D_ADDR_LO, D_WDATA, D_RDATA, D_WRITING} dev_mode_t;

  typedef struct packed {
    dev_mode_t mode;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [2:0] strap_m;
    logic [2:0] strap_s;
    logic guard_m;
    logic guard_s;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd_dir;
    logic m_ack;
    logic guard_hit;
    logic drive_low;
    logic busy;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_BYTES-1:0] pvalid;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [15:0] wtimer;
    logic [PAGE_W-1:0] widx;
  } dev_state_t;

  dev_state_t r;
  dev_state_t next_r;

  // R1 byte array
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rd_byte;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic load_read;

  // R18 rising clock edge
  assign scl_rise = r.scl_s & ~r.scl_d;
  assign scl_fall = ~r.scl_s & r.scl_d;
  // R12 start detect
  assign start_seen = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  // R14 stop detect
  assign stop_seen = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

  assign rd_byte = mem[r.addr];
  assign mem_wa = {r.addr[ADDR_W-1:PAGE_W], r.widx};
  assign mem_wd = r.pbuf[r.widx];
  // R8 top quarter write guard, sampled from Start to end of address
  assign mem_we = (r.mode == D_WRITING) && r.pvalid[r.widx] &&
                  !(r.guard_hit && (r.addr[ADDR_W-1 -: 2] == GUARD_QUARTER));

  always_comb begin
    next_r = r;
    load_read = 1'b0;
    // Pins cross two flip-flops before any logic looks at them
    // R21 sync delay stays far inside a 400 kHz bit
    next_r.scl_m = link.scl;
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = link.sda;
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
    next_r.strap_m = {STRAP_ADDR_BIT2, STRAP_ADDR_BIT1, STRAP_ADDR_BIT0};
    next_r.strap_s = r.strap_m;
    // R9 low guard leaves the whole array writable
    next_r.guard_m = UPPER_QUARTER_WRITE_GUARD;
    next_r.guard_s = r.guard_m;

    if (r.mode == D_WRITING) begin
      // R13 deaf to the bus while the write cycle runs
      next_r.widx = r.widx + 1'b1;
      if (r.wtimer == '0) begin
        next_r.mode = D_IDLE;
        next_r.busy = 1'b0;
        next_r.pvalid = '0;
      end else begin
        next_r.wtimer = r.wtimer - 1'b1;
      end
    end else if (start_seen) begin
      // R13 start accepted in any other state
      // R2 select byte follows every Start
      next_r.mode = D_SEL;
      // Armed one slot early: the clock fall closing the Start is no bit
      next_r.bitn = '1;
      next_r.drive_low = 1'b0;
      next_r.guard_hit = r.guard_s;
      next_r.pvalid = '0;
    end else if (stop_seen) begin
      next_r.drive_low = 1'b0;
      // R16 stop in the slot right after a data ack starts the write
      if (r.mode == D_WDATA && r.bitn == FIRST_BIT && |r.pvalid) begin
        next_r.mode = D_WRITING;
        next_r.busy = 1'b1;
        next_r.wtimer = 16'(WRITE_CYCLES - 1);
        next_r.widx = '0;
      end else begin
        // R15 stop ends the exchange, back to standby
        next_r.mode = D_IDLE;
      end
    end else if (r.mode != D_IDLE) begin
      if (scl_rise) begin
        if (r.bitn == ACK_BIT) begin
          // R3 master acknowledge of a read byte
          next_r.m_ack = ~r.sda_s;
        end else if (r.mode != D_RDATA) begin
          // R10 shifted in MSB first
          next_r.sh = {r.sh[6:0], r.sda_s};
        end
      end else if (scl_fall) begin
        if (r.bitn == LAST_DATA_BIT) begin
          next_r.bitn = ACK_BIT;
          // R17 receiver pulls the ninth bit low
          next_r.drive_low = 1'b1;
          case (r.mode)
            D_SEL: begin
              // R24 strap mismatch deselects
              // R7 strap compare
              if (r.sh[SEL_TYPE_MSB:SEL_TYPE_LSB] != TYPE_ID ||
                  r.sh[SEL_STRAP_MSB:SEL_STRAP_LSB] != r.strap_s) begin
                next_r.mode = D_IDLE;
                next_r.drive_low = 1'b0;
              end else begin
                next_r.rd_dir = r.sh[SEL_DIR_BIT];
              end
            end
            D_ADDR_HI: begin
              // R11 upper address byte, high bits beyond array dropped
              next_r.addr[ADDR_W-1:ADDR_LO_W] = r.sh[ADDR_W-ADDR_LO_W-1:0];
            end
            D_ADDR_LO: begin
              next_r.addr[ADDR_LO_W-1:0] = r.sh;
            end
            D_WDATA: begin
              // R22 page latch, only the low address bits roll within a row
              next_r.pbuf[r.addr[PAGE_W-1:0]] = r.sh;
              next_r.pvalid[r.addr[PAGE_W-1:0]] = 1'b1;
              next_r.addr[PAGE_W-1:0] = r.addr[PAGE_W-1:0] + 1'b1;
            end
            D_RDATA: begin
              // R17 transmitter releases for the master's ack
              next_r.drive_low = 1'b0;
            end
            default: begin
            end
          endcase
        end else if (r.bitn == ACK_BIT) begin
          next_r.bitn = FIRST_BIT;
          next_r.drive_low = 1'b0;
          case (r.mode)
            D_SEL: begin
              if (r.rd_dir) begin
                load_read = 1'b1;
              end else begin
                next_r.mode = D_ADDR_HI;
              end
            end
            // R23 upper byte before lower byte
            D_ADDR_HI: next_r.mode = D_ADDR_LO;
            D_ADDR_LO: next_r.mode = D_WDATA;
            D_RDATA: begin
              // R15 no-ack ends the read stream
              if (r.m_ack) begin
                load_read = 1'b1;
              end else begin
                next_r.mode = D_IDLE;
              end
            end
            default: begin
            end
          endcase
        end else begin
          next_r.bitn = r.bitn + 1'b1;
          if (r.mode == D_RDATA) begin
            next_r.sh = {r.sh[6:0], 1'b0};
            next_r.drive_low = ~r.sh[6];
          end
        end
      end
    end

    if (load_read) begin
      // Counter rolls over at the end of the array
      next_r.mode = D_RDATA;
      next_r.sh = rd_byte;
      next_r.drive_low = ~rd_byte[7];
      next_r.addr = r.addr + 1'b1;
      next_r.m_ack = 1'b0;
    end

    // R8 guard level seen anywhere from Start to the last address bit counts
    if (next_r.mode == D_SEL || next_r.mode == D_ADDR_HI || next_r.mode == D_ADDR_LO) begin
      next_r.guard_hit = next_r.guard_hit | r.guard_s;
    end
  end

  // R5 held reset keeps the slave idle and the line released
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Array has no reset; contents survive like nonvolatile cells
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // R6 open-drain: only ever pulls low
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = r.drive_low;
  assign BUSY = r.busy;

endmodule // eeprom_dev
`default_nettype wire

// ==== rtl/eeprom_pkg.sv ====
package eeprom_pkg;
  // Clock and link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int SCL_MAX_KHZ = 400;
  // A quarter of the fastest serial clock period, rounded up so the link never runs fast
  localparam int QTR_CYCLES = (CLK_FREQ_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
  // Self-timed nonvolatile write cycle
  localparam int T_WR_NS = 5000;
  localparam int WR_CYCLES = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Array organisation
  localparam int MEM_BYTES = 8192;
  localparam int ADDR_W = 13;
  localparam int ADDR_LO_W = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam logic [1:0] GUARD_QUARTER = 2'h3;

  // Select byte layout; type code value is arbitrary
  localparam logic [3:0] TYPE_ID = 4'h6;
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_STRAP_MSB = 3;
  localparam int SEL_STRAP_LSB = 1;
  localparam int SEL_DIR_BIT = 0;

  // Bit slots inside one byte frame
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // Controller registers
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int CMD_START_B = 0;
  localparam int CMD_STOP_B = 1;
  localparam int CMD_READ_B = 2;
  localparam int CMD_ACK_B = 3;
  localparam int STAT_BUSY_B = 0;
  localparam int STAT_ACK_B = 1;
endpackage

// ==== rtl/two_wire_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_mst_o;
  logic sda_mst_oe;
  logic sda;

  // Open-drain wire with pull-up: any enabled driver showing low wins
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_mst_oe & ~sda_mst_o));

  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport master (output scl, output sda_mst_o, output sda_mst_oe, input sda);
endinterface
`default_nettype wire

// ==== rtl/two_wire_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_wire_master
  import eeprom_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Serial link
  two_wire_if.master link,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);

  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mst_mode_t;

  typedef struct packed {
    mst_mode_t mode;
    logic [7:0] div;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] rx;
    logic want_stop;
    logic rd;
    logic ack_tx;
    logic got_ack;
    logic scl;
    logic drive_low;
    logic sda_m;
    logic sda_s;
    logic [7:0] rdata;
  } mst_state_t;

  mst_state_t r;
  mst_state_t next_r;
  logic tick;

  // R21 quarter-period enable
  // Quarter-period enable keeps the clock at or below the fastest allowed rate
  assign tick = (r.div == 8'(QTR - 1));

  always_comb begin
    next_r = r;
    next_r.sda_m = link.sda;
    next_r.sda_s = r.sda_m;

    if (RD) begin
      next_r.rdata = '0;
      case (ADDR)
        REG_TX: next_r.rdata = r.tx;
        REG_RX: next_r.rdata = r.rx;
        REG_STAT: begin
          next_r.rdata[STAT_BUSY_B] = (r.mode != M_IDLE);
          next_r.rdata[STAT_ACK_B] = r.got_ack;
        end
        default: next_r.rdata = '0;
      endcase
    end
    if (WR && ADDR == REG_TX) begin
      next_r.tx = WDATA;
    end

    if (r.mode == M_IDLE) begin
      next_r.div = '0;
      next_r.ph = '0;
      // Commands written while busy are dropped
      if (WR && ADDR == REG_CMD) begin
        next_r.want_stop = WDATA[CMD_STOP_B];
        next_r.rd = WDATA[CMD_READ_B];
        next_r.ack_tx = WDATA[CMD_ACK_B];
        next_r.bitn = FIRST_BIT;
        next_r.sh = r.tx;
        next_r.mode = WDATA[CMD_START_B] ? M_START : M_BIT;
      end
    end else begin
      next_r.div = tick ? '0 : r.div + 1'b1;
      if (tick) begin
        next_r.ph = r.ph + 1'b1;
        case (r.mode)
          M_START: begin
            case (r.ph)
              2'h0: begin
                next_r.scl = 1'b0;
                next_r.drive_low = 1'b0;
              end
              2'h1: next_r.scl = 1'b1;
              2'h2: next_r.drive_low = 1'b1;
              default: begin
                next_r.scl = 1'b0;
                next_r.mode = M_BIT;
              end
            endcase
          end
          M_BIT: begin
            case (r.ph)
              2'h0: begin
                // R19 data changes only while the clock is low
                if (r.bitn == ACK_BIT) begin
                  next_r.drive_low = r.rd & r.ack_tx;
                end else begin
                  next_r.drive_low = ~r.rd & ~r.sh[7];
                end
              end
              2'h1: next_r.scl = 1'b1;
              2'h2: begin
                if (r.bitn == ACK_BIT) begin
                  next_r.got_ack = ~r.sda_s;
                end else if (r.rd) begin
                  next_r.sh = {r.sh[6:0], r.sda_s};
                end
              end
              default: begin
                next_r.scl = 1'b0;
                if (r.bitn == ACK_BIT) begin
                  next_r.drive_low = 1'b0;
                  next_r.bitn = FIRST_BIT;
                  if (r.rd) begin
                    next_r.rx = r.sh;
                  end
                  // R4 stop only after the ack slot
                  next_r.mode = r.want_stop ? M_STOP : M_IDLE;
                end else begin
                  next_r.bitn = r.bitn + 1'b1;
                  if (!r.rd) begin
                    next_r.sh = {r.sh[6:0], 1'b0};
                  end
                end
              end
            endcase
          end
          M_STOP: begin
            case (r.ph)
              2'h0: next_r.drive_low = 1'b1;
              2'h1: next_r.scl = 1'b1;
              2'h2: next_r.drive_low = 1'b0;
              default: next_r.mode = M_IDLE;
            endcase
          end
          default: next_r.mode = M_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= '0;
      r.scl <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Clock is push-pull, data open-drain
  // R20 only this end makes the clock
  assign link.scl = r.scl;
  assign link.sda_mst_o = 1'b0;
  assign link.sda_mst_oe = r.drive_low;
  assign RDATA = r.rdata;

endmodule // two_wire_master
`default_nettype wire

// ==== tb/eeprom_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module eeprom_asserts #(
  parameter int WRITE_CYCLES = 40
) (
  // Clock and device reset
  input wire logic CLK,
  input wire logic RST_N,
  // Wire level signals
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  // Device status
  input wire logic BUSY
);
  localparam int BUSY_MIN = WRITE_CYCLES - 2;
  localparam int BUSY_MAX = WRITE_CYCLES + 2;
  logic sda_d;
  logic in_frame;
  logic [3:0] since_stop;
  logic [15:0] busy_cnt;

  // Frames seen at the pins, ahead of the device's synchronisers
  always_ff @(posedge CLK) begin
    sda_d <= sda;
    if (!RST_N) begin
      in_frame <= 1'b0;
      since_stop <= 4'hF;
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= BUSY ? busy_cnt + 16'h0001 : 16'h0000;
      if (scl && sda_d && !sda)
        in_frame <= 1'b1;
      if (scl && !sda_d && sda)
        in_frame <= 1'b0;
      if (scl && !sda_d && sda)
        since_stop <= 4'h0;
      else if (since_stop != 4'hF)
        since_stop <= since_stop + 4'h1;
    end
  end

  property p_open_drain;
    @(posedge CLK) disable iff (!RST_N) sda_dev_oe |-> (sda_dev_o == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("device data driver not open drain");
  property p_reset_quiet;
    @(posedge CLK) !RST_N |=> (!sda_dev_oe && !BUSY);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("device active during reset");
  property p_busy_quiet;
    @(posedge CLK) disable iff (!RST_N) BUSY |-> !sda_dev_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("device drives data line while busy");
  property p_edge_scl_low;
    @(posedge CLK) disable iff (!RST_N) ($rose(sda_dev_oe) || $fell(sda_dev_oe)) |-> !scl;
  endproperty
  a_edge_scl_low: assert property (p_edge_scl_low) else $error("device data changed while clock high");
  property p_ack_stands;
    @(posedge CLK) disable iff (!RST_N) $rose(sda_dev_oe) |-> sda_dev_oe [*8];
  endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("device pull shorter than a bit");
  property p_busy_after_stop;
    @(posedge CLK) disable iff (!RST_N) $rose(BUSY) |-> (since_stop < 4'h8);
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("write cycle without a stop");
  property p_busy_len;
    @(posedge CLK) disable iff (!RST_N) $fell(BUSY) |-> (busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_idle_after_stop;
    @(posedge CLK) disable iff (!RST_N) !in_frame |-> !sda_dev_oe;
  endproperty
  a_idle_after_stop: assert property (p_idle_after_stop) else $error("device drives outside a frame");
endmodule // eeprom_asserts
`default_nettype wire

// ==== tb/serial_eeprom_bus_slave_front_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_slave_front_tb;
  import eeprom_pkg::*;
  // Short write cycle and fast link keep the run brief
  localparam int WCYC = 40;
  localparam logic [7:0] C_S = 8'h01 << CMD_START_B;
  localparam logic [7:0] C_P = 8'h01 << CMD_STOP_B;
  localparam logic [7:0] C_R = 8'h01 << CMD_READ_B;
  localparam logic [7:0] C_A = 8'h01 << CMD_ACK_B;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dev_on = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [2:0] strap = 3'h5;
  logic guard = 1'b0;
  logic busy;
  logic dev_rst_n;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  assign dev_rst_n = rst_n & dev_on;
  two_wire_if link ();
  eeprom_dev #(.WRITE_CYCLES(WCYC)) eeprom_dev_i (.CLK(clk), .RST_N(dev_rst_n), .link(link),
    .STRAP_ADDR_BIT0(strap[0]), .STRAP_ADDR_BIT1(strap[1]), .STRAP_ADDR_BIT2(strap[2]),
    .UPPER_QUARTER_WRITE_GUARD(guard), .BUSY(busy));
  two_wire_master #(.QTR(4)) two_wire_master_i (.CLK(clk), .RST_N(rst_n), .link(link),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  eeprom_asserts #(.WRITE_CYCLES(WCYC)) eeprom_asserts_i (.CLK(clk), .RST_N(dev_rst_n), .scl(link.scl),
    .sda(link.sda), .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe), .BUSY(busy));
  always #12.5 clk = ~clk;

  task automatic results;
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // One byte on the link; ack is unknown if the controller never finishes
  task automatic op(input logic [7:0] tx, input logic [7:0] cmd, output logic ack);
    logic [7:0] s;
    bus_wr(REG_TX, tx);
    bus_wr(REG_CMD, cmd);
    s = 8'h01;
    for (int i = 0; i < 400 && s[STAT_BUSY_B] !== 1'b0; i++)
      bus_rd(REG_STAT, s);
    ack = (s[STAT_BUSY_B] === 1'b0) ? s[STAT_ACK_B] : 1'bx;
  endtask
  function automatic logic [7:0] sel(input logic rnw);
    return {TYPE_ID, strap, rnw};
  endfunction
  task automatic write_seq(input logic [15:0] a, input logic [7:0] d0, input int n);
    logic ack;
    op(sel(1'b0), C_S, ack);
    chk(8'(ack), 8'h01);
    op(a[15:8], 8'h00, ack);
    chk(8'(ack), 8'h01);
    op(a[7:0], 8'h00, ack);
    chk(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      op(d0 + 8'(i), (i == n - 1) ? C_P : 8'h00, ack);
      if (!guard)
        chk(8'(ack), 8'h01);
    end
  endtask
  // A blocked write still starts a cycle, but a select alone starts none, so the caller decides
  task automatic wait_idle(input logic check);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (busy === 1'b1)
        seen = 1'b1;
      if (seen && busy === 1'b0)
        break;
    end
    if (check)
      chk(8'(seen), 8'h01);
    chk(8'(busy), 8'h00);
  endtask
  task automatic read_seq(input logic [15:0] a, input logic [7:0] d0, input int n);
    logic ack;
    logic [7:0] got;
    op(sel(1'b0), C_S, ack);
    op(a[15:8], 8'h00, ack);
    op(a[7:0], 8'h00, ack);
    op(sel(1'b1), C_S, ack);
    chk(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      op(8'h00, (i == n - 1) ? (C_R | C_P) : (C_R | C_A), ack);
      bus_rd(REG_RX, got);
      chk(got, d0 + 8'(i));
    end
  endtask

  task automatic t_page;
    write_seq(16'h0040, 8'hA0, PAGE_BYTES);
    wait_idle(1'b1);
    read_seq(16'h0040, 8'hA0, PAGE_BYTES);
  endtask
  task automatic t_roll;
    write_seq(16'h1FFF, 8'h3C, 1);
    wait_idle(1'b1);
    write_seq(16'h0000, 8'h3D, 1);
    wait_idle(1'b1);
    read_seq(16'h1FFF, 8'h3C, 2);
  endtask
  task automatic t_guard;
    write_seq(16'h1800, 8'h11, 1);
    wait_idle(1'b1);
    @(posedge clk);
    guard <= 1'b1;
    write_seq(16'h1800, 8'h22, 1);
    wait_idle(1'b0);
    write_seq(16'h07FF, 8'h33, 1);
    wait_idle(1'b1);
    @(posedge clk);
    guard <= 1'b0;
    read_seq(16'h1800, 8'h11, 1);
    read_seq(16'h07FF, 8'h33, 1);
  endtask
  task automatic t_poll;
    logic ack;
    write_seq(16'h0200, 8'h77, 1);
    repeat (4) @(negedge clk);
    chk(8'(busy), 8'h01);
    op(sel(1'b0), C_S | C_P, ack);
    chk(8'(ack), 8'h00);
    wait_idle(1'b0);
    read_seq(16'h0200, 8'h77, 1);
  endtask
  task automatic t_reset;
    logic ack;
    @(posedge clk);
    dev_on <= 1'b0;
    op(sel(1'b0), C_S | C_P, ack);
    chk(8'(ack), 8'h00);
    @(posedge clk);
    dev_on <= 1'b1;
    repeat (4) @(posedge clk);
    read_seq(16'h0200, 8'h77, 1);
  endtask
  task automatic t_select;
    logic ack;
    logic [7:0] got;
    logic [7:0] bad [4];
    bad = '{sel(1'b0) ^ 8'h02, sel(1'b0) ^ 8'h04, sel(1'b0) ^ 8'h08, sel(1'b0) ^ 8'h80};
    foreach (bad[i]) begin
      op(bad[i], C_S | C_P, ack);
      chk(8'(ack), 8'h00);
    end
    @(posedge clk);
    strap <= 3'h2;
    repeat (4) @(posedge clk);
    op(sel(1'b0), C_S | C_P, ack);
    chk(8'(ack), 8'h01);
    wait_idle(1'b0);
    chk(8'({link.scl, link.sda}), 8'h03);
    bus_rd(8'h10, got);
    chk(got, 8'h00);
  endtask

  // Hang guard well above the expected run of about 20000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_page();
    t_roll();
    t_guard();
    t_poll();
    t_reset();
    t_select();
    results();
  end
endmodule // serial_eeprom_bus_slave_front_tb
`default_nettype wire
